// *** src/gauge_event_flag_register.sv ***
// gauge event flag register with mask, self-clearing clears and alert pin
// Functional notes
// - flag register sets only from hardware; host writes to it are ignored
// - clear bits written one fall back to zero the next cycle by themselves
// - bit 0 sets on pack over-temperature
// - bit 1 sets on pack link transaction error
// - bit 2 sets on pack under-voltage
// - bit 3 sets when charge meets or exceeds high threshold
// - bit 4 sets on under-temperature alarm
// - bit 5 is a heartbeat the firmware sets
// - bit 6 sets on limit-check threshold detection
// - bit 7 sets on zero charge declared
// - bit 8 sets when charge reaches or falls below low threshold
// - bit 9 sets when charge rises back above low threshold
// - bit 10 sets when gauging becomes active
// - bit 11 sets when ready for configuration
// - bit 12 sets on watchdog expiry
// - bit 13 sets on relay master transaction complete
// - bit 14 sets on almost-full charge
// - bit 15 sets when pack voltage exceeds threshold
// - each flag has a mask bit, zero enables, resets to zero
// - each flag has a self-clearing clear bit written as one
`timescale 1ns/1ps
module gauge_event_flag_register
    import event_flag_pkg::*;
#(
    parameter int FLAGS = FLAG_COUNT
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // register port from the serial management slave
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [FLAGS-1:0] reg_wdata,
    output logic      [FLAGS-1:0] reg_rdata,
    // hardware event conditions (levels)
    input  wire logic             over_temperature,
    input  wire logic             pack_link_error,
    input  wire logic             under_voltage,
    input  wire logic [7:0]       charge_level,
    input  wire logic [7:0]       high_charge_threshold,
    input  wire logic [7:0]       low_charge_threshold,
    input  wire logic             under_temperature,
    input  wire logic             limit_test_hit,
    input  wire logic             empty_charge,
    input  wire logic             gauging_active,
    input  wire logic             config_ready,
    input  wire logic             watchdog_expired,
    input  wire logic             relay_master_done,
    input  wire logic             near_full,
    input  wire logic             pack_overvolt,
    // firmware pulse
    input  wire logic             firmware_pulse,
    // alert pin and status
    output logic                  alert_n,
    output logic      [FLAGS-1:0] event_flags,
    output logic      [FLAGS-1:0] event_masks
);
    logic [FLAGS-1:0] cond_lvl;
    logic [FLAGS-1:0] cond_rise;
    logic [FLAGS-1:0] set_vec;
    logic [FLAGS-1:0] flag_vec;
    logic [FLAGS-1:0] mask_r;
    logic [FLAGS-1:0] clear_r;
    logic [FLAGS-1:0] rdata_nxt;
    logic [FLAGS-1:0] rdata_r;
    logic             alert_n_r;
    logic             high_hit;
    logic             low_hit;

    // charge comparisons against the alarm thresholds
    assign high_hit = charge_level >= high_charge_threshold;
    assign low_hit  = charge_level <= low_charge_threshold;

    // levels are edge-detected so a clear holds until the cause recurs
    always_comb
    begin
        cond_lvl                    = '0;
        cond_lvl[OVER_TEMP_BIT]     = over_temperature;
        cond_lvl[PACK_LINK_ERR_BIT] = pack_link_error;
        cond_lvl[UNDER_VOLT_BIT]    = under_voltage;
        cond_lvl[HIGH_CHARGE_BIT]   = high_hit;
        cond_lvl[UNDER_TEMP_BIT]    = under_temperature;
        cond_lvl[FW_PULSE_BIT]      = firmware_pulse;
        cond_lvl[LIMIT_TEST_BIT]    = limit_test_hit;
        cond_lvl[EMPTY_CHARGE_BIT]  = empty_charge;
        cond_lvl[LOW_ENTER_BIT]     = low_hit;
        cond_lvl[LOW_EXIT_BIT]      = ~low_hit;
        cond_lvl[GAUGE_ACTIVE_BIT]  = gauging_active;
        cond_lvl[CONFIG_READY_BIT]  = config_ready;
        cond_lvl[WATCHDOG_BIT]      = watchdog_expired;
        cond_lvl[RELAY_DONE_BIT]    = relay_master_done;
        cond_lvl[NEAR_FULL_BIT]     = near_full;
        cond_lvl[PACK_OVERVOLT_BIT] = pack_overvolt;
    end

    event_edge_detect #(
        .WIDTH    (FLAGS)
    ) u_edge (
        .clk      (clk),
        .rst_n    (rst_n),
        .level_in (cond_lvl),
        .rise_out (cond_rise)
    );

    // exit flag needs a prior stay at or below: the edge detector starts at zero,
    // so a charge already above threshold at reset would fire without this guard
    logic been_low_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            been_low_r <= 1'b0;
        else if (low_hit)
            been_low_r <= 1'b1;
    end

    always_comb
    begin
        set_vec               = cond_rise;
        set_vec[LOW_EXIT_BIT] = cond_rise[LOW_EXIT_BIT] & been_low_r;
    end

    genvar gi;
    generate
        for (gi = 0; gi < FLAGS; gi++)
        begin : g_flag
            event_flag_bit u_bit (
                .clk     (clk),
                .rst_n   (rst_n),
                .set_evt (set_vec[gi]),
                .clr_evt (clear_r[gi]),
                .flag_r  (flag_vec[gi])
            );
        end
    endgenerate

    // mask register, zero enables
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_r <= MASKS_RESET;
        else if (reg_wr && reg_addr == EVENT_MASKS_ADDR)
            mask_r <= reg_wdata;
    end

    // clear bits hold one cycle then return to zero without host help
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            clear_r <= '0;
        else if (reg_wr && reg_addr == EVENT_CLEAR_ADDR)
            clear_r <= reg_wdata;
        else
            clear_r <= '0;
    end

    // writes to the flag address are dropped: no path from reg_wdata to flags
    always_comb
    begin
        rdata_nxt = READ_IDLE_VALUE;
        case (reg_addr)
            EVENT_FLAGS_ADDR: rdata_nxt = flag_vec;
            EVENT_MASKS_ADDR: rdata_nxt = mask_r;
            EVENT_CLEAR_ADDR: rdata_nxt = clear_r;
            default:          rdata_nxt = READ_IDLE_VALUE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= READ_IDLE_VALUE;
        else if (reg_rd)
            rdata_r <= rdata_nxt;
    end

    // registered alert avoids glitches on the pin
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            alert_n_r <= 1'b1;
        else
            alert_n_r <= ~|(flag_vec & ~mask_r);
    end

    assign reg_rdata   = rdata_r;
    assign alert_n     = alert_n_r;
    assign event_flags = flag_vec;
    assign event_masks = mask_r;
endmodule

// *** src/event_flag_pkg.sv ***
// constants shared by the gauge event flag block
package event_flag_pkg;
    localparam int          FLAG_COUNT          = 16;
    localparam logic [7:0]  EVENT_FLAGS_ADDR    = 8'h0a;
    localparam logic [7:0]  EVENT_MASKS_ADDR    = 8'h0b;
    localparam logic [7:0]  EVENT_CLEAR_ADDR    = 8'h0c;
    localparam logic [15:0] FLAGS_RESET         = 16'h0000;
    localparam logic [15:0] MASKS_RESET         = 16'h0000;
    localparam logic [15:0] READ_IDLE_VALUE     = 16'h0000;
    localparam int          OVER_TEMP_BIT       = 0;
    localparam int          PACK_LINK_ERR_BIT   = 1;
    localparam int          UNDER_VOLT_BIT      = 2;
    localparam int          HIGH_CHARGE_BIT     = 3;
    localparam int          UNDER_TEMP_BIT      = 4;
    localparam int          FW_PULSE_BIT        = 5;
    localparam int          LIMIT_TEST_BIT      = 6;
    localparam int          EMPTY_CHARGE_BIT    = 7;
    localparam int          LOW_ENTER_BIT       = 8;
    localparam int          LOW_EXIT_BIT        = 9;
    localparam int          GAUGE_ACTIVE_BIT    = 10;
    localparam int          CONFIG_READY_BIT    = 11;
    localparam int          WATCHDOG_BIT        = 12;
    localparam int          RELAY_DONE_BIT      = 13;
    localparam int          NEAR_FULL_BIT       = 14;
    localparam int          PACK_OVERVOLT_BIT   = 15;
endpackage

// *** src/event_flag_bit.sv ***
// one sticky event flag: set by hardware, cleared by host
`timescale 1ns/1ps
module event_flag_bit
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control
    input  wire logic set_evt,
    input  wire logic clr_evt,
    // state
    output logic      flag_r
);
    // set wins over a coinciding clear so no event is lost
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_r <= 1'b0;
        else if (set_evt)
            flag_r <= 1'b1;
        else if (clr_evt)
            flag_r <= 1'b0;
    end
endmodule

// *** src/event_edge_detect.sv ***
// rising edge detector that turns an event level into a one-cycle set pulse
`timescale 1ns/1ps
module event_edge_detect
#(
    parameter int WIDTH = 16
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] level_in,
    // pulses
    output logic      [WIDTH-1:0] rise_out
);
    logic [WIDTH-1:0] prev_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_r <= '0;
        else
            prev_r <= level_in;
    end

    assign rise_out = level_in & ~prev_r;
endmodule

// *** testbench/gauge_event_flag_register_sva.sv ***
// checker for the gauge event flag register ports
`timescale 1ns/1ps
module event_flag_checker
    import event_flag_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        over_temperature,
    input wire logic        firmware_pulse,
    input wire logic        alert_n,
    input wire logic [15:0] event_flags,
    input wire logic [15:0] event_masks
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_alert_follows: assert property (alert_n ==
        !(|($past(event_flags) & ~$past(event_masks))))
        else $error("alert does not follow unmasked flags");
    a_flag_sticky: assert property ((|($past(event_flags) & ~event_flags
        & ~(($past(reg_wr, 2) && $past(reg_addr, 2) == EVENT_CLEAR_ADDR)
        ? $past(reg_wdata, 2) : 16'h0000))) == 1'b0)
        else $error("flag dropped without a clear");
    a_hot_sets: assert property ($rose(over_temperature) |=> event_flags[OVER_TEMP_BIT])
        else $error("over temperature flag not set");
    a_only_hardware: assert property ($rose(event_flags[OVER_TEMP_BIT])
        |-> $past(over_temperature) && !$past(over_temperature, 2))
        else $error("flag rose without its cause");
    a_pulse_sets: assert property ($rose(firmware_pulse) |=> event_flags[FW_PULSE_BIT])
        else $error("firmware pulse flag not set");
    a_mask_write: assert property (reg_wr && reg_addr == EVENT_MASKS_ADDR
        |=> event_masks == $past(reg_wdata))
        else $error("mask write lost");
    a_mask_hold: assert property (!(reg_wr && reg_addr == EVENT_MASKS_ADDR)
        |=> $stable(event_masks))
        else $error("mask changed without a write");
    a_read_flags: assert property (reg_rd && reg_addr == EVENT_FLAGS_ADDR
        |=> reg_rdata == $past(event_flags))
        else $error("flag read returned wrong value");
    a_clear_self: assert property (reg_rd && reg_addr == EVENT_CLEAR_ADDR
        && !$past(reg_wr) |=> reg_rdata == 16'h0000)
        else $error("clear bits did not self clear");
endmodule
bind gauge_event_flag_register event_flag_checker u_chk (.*);

// *** testbench/host_model.sv ***
// host processor model driving the register port
`timescale 1ns/1ps
module host_model
(
    // clock
    input  wire logic        clk,
    // register port
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    // data is inverted once released so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule

// *** testbench/gauge_event_flag_register_tb.sv ***
// self-checking bench for the gauge event flag register
`timescale 1ns/1ps
module gauge_event_flag_register_tb;
    import event_flag_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] ev = '0;
    logic [7:0]  lvl = 8'h32;
    logic [7:0]  hi_th = 8'h50;
    logic [7:0]  lo_th = 8'h14;
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        alert_n;
    logic [15:0] flags;
    logic [15:0] masks;
    logic [15:0] d;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;
    host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
        .reg_rdata(rdata));
    gauge_event_flag_register dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr),
        .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .over_temperature(ev[0]),
        .pack_link_error(ev[1]), .under_voltage(ev[2]), .charge_level(lvl),
        .high_charge_threshold(hi_th), .low_charge_threshold(lo_th), .under_temperature(ev[4]),
        .limit_test_hit(ev[6]), .empty_charge(ev[7]), .gauging_active(ev[10]),
        .config_ready(ev[11]), .watchdog_expired(ev[12]), .relay_master_done(ev[13]),
        .near_full(ev[14]), .pack_overvolt(ev[15]), .firmware_pulse(ev[5]),
        .alert_n(alert_n), .event_flags(flags), .event_masks(masks));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask
    task automatic t_reset();
        chk(flags, 16'h0000);
        chk(masks, 16'h0000);
        chk({15'h0, alert_n}, 16'h0001);
    endtask
    // every single-bit event except charge bits 3, 8 and 9: set, persist after cause drops, then clear
    task automatic t_events();
        for (int k = 0; k < FLAG_COUNT; k++)
        begin
            if (k == 3 || k == 8 || k == 9)
                continue;
            ev[k] = 1'b1;
            settle();
            chk(flags, 16'h1 << k);
            chk({15'h0, alert_n}, 16'h0000);
            ev[k] = 1'b0;
            settle();
            chk(flags, 16'h1 << k);
            host.wr(EVENT_CLEAR_ADDR, 16'h1 << k);
            settle();
            chk(flags, 16'h0000);
            chk({15'h0, alert_n}, 16'h0001);
        end
    endtask
    // charge crosses high, then low, then back above low
    task automatic t_charge();
        lvl = 8'h50;
        settle();
        chk(flags, 16'h0008);
        lvl = 8'h14;
        settle();
        chk(flags, 16'h0108);
        lvl = 8'h15;
        settle();
        chk(flags, 16'h0308);
        host.wr(EVENT_CLEAR_ADDR, 16'hffff);
        settle();
        chk(flags, 16'h0000);
    endtask
    task automatic t_regs();
        host.wr(EVENT_MASKS_ADDR, 16'hffff);
        ev[12] = 1'b1;
        settle();
        chk({15'h0, alert_n}, 16'h0001);
        host.wr(EVENT_FLAGS_ADDR, 16'hffff);
        host.rd(EVENT_FLAGS_ADDR, d);
        chk(d, 16'h1000);
        host.rd(EVENT_MASKS_ADDR, d);
        chk(d, 16'hffff);
        host.wr(EVENT_MASKS_ADDR, 16'h0000);
        settle();
        chk({15'h0, alert_n}, 16'h0000);
        host.wr(EVENT_CLEAR_ADDR, 16'h1000);
        host.rd(EVENT_CLEAR_ADDR, d);
        chk(d, 16'h0000);
        host.rd(8'h33, d);
        chk(d, 16'h0000);
        host.wr(EVENT_MASKS_ADDR, 16'h0000);
        settle();
        chk(flags, 16'h0000);
        chk({15'h0, alert_n}, 16'h0001);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (3) @(negedge clk);
        t_reset();
        rst_n = 1'b1;
        t_events();
        t_charge();
        t_regs();
        end_of_test();
    end
endmodule
